/* src/rrc_core.sv */
// What this block does
// - Return pops stack, top loads program counter.
// - Shadow operand one restores accumulator, flags, bank.
// - Shadow operand zero leaves those registers alone.
// - Return decoded from pattern, bit zero is shadow.
// - Return: one word, two cycles, pop in Q4.
// - Return leaves latches untouched; flags change only on a shadow restore.
// - Rotate left; bit7 to carry, carry to bit0.
// - Destination zero gives accumulator, one gives file.
// - Bank operand zero access bank, one uses bank.
// - Extended set, low addresses use indexed offset.
// - Adding accumulator to low byte jumps into table.
`timescale 1ns/100ps
module rrc_core (
   input  wire logic                        i_clk,
   input  wire logic                        i_srst,
   input  wire logic [15:0]                 i_instr,
   input  wire logic [rrc_pkg::PC_W-1:0]    i_stack_top,
   input  wire logic [7:0]                  i_accumulator_shadow,
   input  wire logic [7:0]                  i_flag_shadow,
   input  wire logic [rrc_pkg::BSR_W-1:0]   i_bank_select_shadow,
   input  wire logic [rrc_pkg::PCU_W-1:0]   i_pc_upper_latch,
   input  wire logic [7:0]                  i_pc_high_latch,
   input  wire logic                        i_ext_en,
   input  wire logic [rrc_pkg::ADDR_W-1:0]  i_fsr2,
   input  wire logic [7:0]                  i_file_rdata,
   output logic      [rrc_pkg::PC_W-1:0]    o_pc,
   output logic      [7:0]                  o_acc,
   output logic      [7:0]                  o_flags,
   output logic      [rrc_pkg::BSR_W-1:0]   o_bank_select_register,
   output logic      [1:0]                  o_phase,
   output logic                             o_instr_taken,
   output logic                             o_stack_pop,
   output logic      [rrc_pkg::ADDR_W-1:0]  o_file_addr,
   output logic                             o_file_rd,
   output logic                             o_file_wr,
   output logic      [7:0]                  o_file_wdata
);

   rrc_pkg::rrc_phase_e               phase_q;
   rrc_pkg::rrc_phase_e               phase_d;
   rrc_pkg::rrc_cycle_e               cycle_q;
   rrc_pkg::rrc_cycle_e               cycle_d;
   rrc_pkg::rrc_op_e                  op_q;
   rrc_pkg::rrc_op_e                  op_d;
   logic [15:0]                       instr_q;
   logic [15:0]                       instr_d;
   logic [rrc_pkg::PC_W-1:0]          pc_q;
   logic [rrc_pkg::PC_W-1:0]          pc_d;
   logic [7:0]                        acc_q;
   logic [7:0]                        acc_d;
   logic [7:0]                        flags_q;
   logic [7:0]                        flags_d;
   logic [rrc_pkg::BSR_W-1:0]         bsr_q;
   logic [rrc_pkg::BSR_W-1:0]         bsr_d;
   logic [7:0]                        result_q;
   logic [7:0]                        result_d;
   logic [7:0]                        new_flags_q;
   logic [7:0]                        new_flags_d;
   logic [rrc_pkg::ADDR_W-1:0]        addr_q;
   logic [rrc_pkg::ADDR_W-1:0]        addr_d;
   logic                              taken_q;
   logic                              taken_d;
   logic                              pop_q;
   logic                              pop_d;
   logic                              rd_q;
   logic                              rd_d;
   logic                              wr_q;
   logic                              wr_d;
   logic [7:0]                        wdata_q;
   logic [7:0]                        wdata_d;

   logic [rrc_pkg::ADDR_W-1:0]        eff_addr;
   logic [7:0]                        rot_result;
   logic                              rot_carry;
   logic                              rot_neg;
   logic                              rot_zero;
   logic [8:0]                        add_sum;
   logic [4:0]                        add_half;
   logic                              add_ov;
   rrc_pkg::rrc_op_e                  dec_op;
   logic                              dest_file;

   rrc_addr rrc_addr_i (
      .i_f                    (instr_q[7:0]),
      .i_bank_sel             (instr_q[rrc_pkg::BIT_BANK]),
      .i_bank_select_register (bsr_q),
      .i_ext_en               (i_ext_en),
      .i_fsr2                 (i_fsr2),
      .o_addr                 (eff_addr)
   );

   rrc_rotate rrc_rotate_i (
      .i_data   (i_file_rdata),
      .i_carry  (flags_q[rrc_pkg::FLAG_C]),
      .o_result (rot_result),
      .o_carry  (rot_carry),
      .o_neg    (rot_neg),
      .o_zero   (rot_zero)
   );

   // Decode of the word presented in Q1.
   always_comb begin
      if ((i_instr & rrc_pkg::OPC_RETURN_MASK) == rrc_pkg::OPC_RETURN) begin
         dec_op = rrc_pkg::OP_RETURN;
      end else if (i_instr[15:8] == rrc_pkg::OPC_LITRET_HI) begin
         dec_op = rrc_pkg::OP_LITRET;
      end else if (i_instr[15:10] == rrc_pkg::OPC_ROTATE_HI) begin
         dec_op = rrc_pkg::OP_ROTATE;
      end else if (i_instr[15:10] == rrc_pkg::OPC_ADD_HI) begin
         dec_op = rrc_pkg::OP_ADD;
      end else begin
         dec_op = rrc_pkg::OP_NONE;
      end
   end

   always_comb begin
      add_sum   = {1'b0, i_file_rdata} + {1'b0, acc_q};
      add_half  = {1'b0, i_file_rdata[3:0]} + {1'b0, acc_q[3:0]};
      add_ov    = (i_file_rdata[7] == acc_q[7]) &&
                  (add_sum[7] != acc_q[7]);
      dest_file = instr_q[rrc_pkg::BIT_DEST];
   end

   always_comb begin
      phase_d     = phase_q;
      cycle_d     = cycle_q;
      op_d        = op_q;
      instr_d     = instr_q;
      pc_d        = pc_q;
      acc_d       = acc_q;
      flags_d     = flags_q;
      bsr_d       = bsr_q;
      result_d    = result_q;
      new_flags_d = new_flags_q;
      addr_d      = addr_q;
      taken_d     = 1'b0;
      pop_d       = 1'b0;
      rd_d        = 1'b0;
      wr_d        = 1'b0;
      wdata_d     = wdata_q;

      unique case (phase_q)
         rrc_pkg::PH_Q1: begin
            phase_d = rrc_pkg::PH_Q2;
            if (cycle_q == rrc_pkg::CYC_EXEC) begin
               instr_d = i_instr;
               op_d    = dec_op;
               taken_d = 1'b1;
            end else begin
               // Second cycle of a flow change does nothing.
               op_d = rrc_pkg::OP_NONE;
            end
         end
         rrc_pkg::PH_Q2: begin
            phase_d = rrc_pkg::PH_Q3;
            if ((op_q == rrc_pkg::OP_ROTATE) ||
                (op_q == rrc_pkg::OP_ADD)) begin
               addr_d = eff_addr;
               rd_d   = 1'b1;
            end
         end
         rrc_pkg::PH_Q3: begin
            phase_d     = rrc_pkg::PH_Q4;
            new_flags_d = flags_q;
            if (op_q == rrc_pkg::OP_ROTATE) begin
               result_d = rot_result;
               new_flags_d[rrc_pkg::FLAG_C] = rot_carry;
               new_flags_d[rrc_pkg::FLAG_N] = rot_neg;
               new_flags_d[rrc_pkg::FLAG_Z] = rot_zero;
            end else if (op_q == rrc_pkg::OP_ADD) begin
               result_d = add_sum[7:0];
               new_flags_d[rrc_pkg::FLAG_C]  = add_sum[8];
               new_flags_d[rrc_pkg::FLAG_DC] = add_half[4];
               new_flags_d[rrc_pkg::FLAG_Z]  = (add_sum[7:0] == 8'h00);
               new_flags_d[rrc_pkg::FLAG_OV] = add_ov;
               new_flags_d[rrc_pkg::FLAG_N]  = add_sum[7];
            end
         end
         rrc_pkg::PH_Q4: begin
            phase_d = rrc_pkg::PH_Q1;
            cycle_d = rrc_pkg::CYC_EXEC;
            pc_d    = pc_q + rrc_pkg::PC_STEP;
            unique case (op_q)
               rrc_pkg::OP_RETURN: begin
                  pop_d   = 1'b1;
                  pc_d    = i_stack_top;
                  cycle_d = rrc_pkg::CYC_NOP;
                  if (instr_q[rrc_pkg::BIT_SHADOW]) begin
                     acc_d   = i_accumulator_shadow;
                     flags_d = i_flag_shadow;
                     bsr_d   = i_bank_select_shadow;
                  end
                  // With the operand clear nothing else moves.
               end
               rrc_pkg::OP_LITRET: begin
                  pop_d   = 1'b1;
                  pc_d    = i_stack_top;
                  acc_d   = instr_q[7:0];
                  cycle_d = rrc_pkg::CYC_NOP;
               end
               rrc_pkg::OP_ROTATE: begin
                  flags_d = new_flags_q;
                  if (dest_file) begin
                     wr_d    = 1'b1;
                     wdata_d = result_q;
                  end else begin
                     acc_d = result_q;
                  end
               end
               rrc_pkg::OP_ADD: begin
                  flags_d = new_flags_q;
                  if (!dest_file) begin
                     acc_d = result_q;
                  end else if (addr_q == rrc_pkg::PCL_ADDR) begin
                     // Writing the low byte loads the upper bytes from
                     // the latches, which makes the computed jump.
                     pc_d    = {i_pc_upper_latch, i_pc_high_latch,
                                result_q};
                     cycle_d = rrc_pkg::CYC_NOP;
                  end else begin
                     wr_d    = 1'b1;
                     wdata_d = result_q;
                  end
               end
               rrc_pkg::OP_NONE: begin
                  if (cycle_q == rrc_pkg::CYC_NOP) begin
                     // The target was loaded in the first cycle.
                     pc_d = pc_q;
                  end
               end
               default: begin
                  pc_d = pc_q;
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         phase_q     <= rrc_pkg::PH_Q1;
         cycle_q     <= rrc_pkg::CYC_EXEC;
         op_q        <= rrc_pkg::OP_NONE;
         instr_q     <= 16'h0000;
         pc_q        <= rrc_pkg::PC_RST;
         acc_q       <= rrc_pkg::ACC_RST;
         flags_q     <= rrc_pkg::FLG_RST;
         bsr_q       <= rrc_pkg::BSR_RST;
         result_q    <= 8'h00;
         new_flags_q <= rrc_pkg::FLG_RST;
         addr_q      <= 12'h000;
         taken_q     <= 1'b0;
         pop_q       <= 1'b0;
         rd_q        <= 1'b0;
         wr_q        <= 1'b0;
         wdata_q     <= 8'h00;
      end else begin
         phase_q     <= phase_d;
         cycle_q     <= cycle_d;
         op_q        <= op_d;
         instr_q     <= instr_d;
         pc_q        <= pc_d;
         acc_q       <= acc_d;
         flags_q     <= flags_d;
         bsr_q       <= bsr_d;
         result_q    <= result_d;
         new_flags_q <= new_flags_d;
         addr_q      <= addr_d;
         taken_q     <= taken_d;
         pop_q       <= pop_d;
         rd_q        <= rd_d;
         wr_q        <= wr_d;
         wdata_q     <= wdata_d;
      end
   end

   always_comb begin
      o_pc                   = pc_q;
      o_acc                  = acc_q;
      o_flags                = flags_q;
      o_bank_select_register = bsr_q;
      o_phase                = phase_q;
      o_instr_taken          = taken_q;
      o_stack_pop            = pop_q;
      o_file_addr            = addr_q;
      o_file_rd              = rd_q;
      o_file_wr              = wr_q;
      o_file_wdata           = wdata_q;
   end

endmodule

/* src/rrc_pkg.sv */
package rrc_pkg;

   localparam int PC_W   = 21;
   localparam int ADDR_W = 12;
   localparam int BSR_W  = 4;
   localparam int PCU_W  = 5;

   // Flag register bit positions.
   localparam int FLAG_C  = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N  = 4;

   // Opcode patterns.
   localparam logic [15:0] OPC_RETURN      = 16'h0012;
   localparam logic [15:0] OPC_RETURN_MASK = 16'hfffe;
   localparam logic [7:0]  OPC_LITRET_HI   = 8'h0c;
   localparam logic [5:0]  OPC_ROTATE_HI   = 6'h0d;
   localparam logic [5:0]  OPC_ADD_HI      = 6'h09;

   // Operand bit positions inside the instruction word.
   localparam int BIT_SHADOW = 0;
   localparam int BIT_DEST   = 9;
   localparam int BIT_BANK   = 8;

   // Address map of the file register space.
   localparam logic [7:0]        ACCESS_SPLIT  = 8'h60;
   localparam logic [7:0]        INDEXED_LIMIT = 8'h5f;
   localparam logic [3:0]        SFR_PAGE      = 4'hf;
   localparam logic [ADDR_W-1:0] PCL_ADDR      = 12'hff9;

   // Reset values and program counter step.
   localparam logic [PC_W-1:0] PC_RST  = 21'h000000;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [7:0]      ACC_RST = 8'h00;
   localparam logic [7:0]      FLG_RST = 8'h00;
   localparam logic [BSR_W-1:0] BSR_RST = 4'h0;

   typedef enum logic [1:0] {
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } rrc_phase_e;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_RETURN,
      OP_LITRET,
      OP_ROTATE,
      OP_ADD
   } rrc_op_e;

   typedef enum logic {
      CYC_EXEC,
      CYC_NOP
   } rrc_cycle_e;

endpackage

/* src/rrc_addr.sv */
`timescale 1ns/100ps
module rrc_addr (
   input  wire logic [7:0]                    i_f,
   input  wire logic                          i_bank_sel,
   input  wire logic [rrc_pkg::BSR_W-1:0]     i_bank_select_register,
   input  wire logic                          i_ext_en,
   input  wire logic [rrc_pkg::ADDR_W-1:0]    i_fsr2,
   output logic      [rrc_pkg::ADDR_W-1:0]    o_addr
);

   always_comb begin
      if (i_bank_sel) begin
         o_addr = {i_bank_select_register, i_f};
      end else if (i_ext_en && (i_f <= rrc_pkg::INDEXED_LIMIT)) begin
         // The offset wraps inside the data space on purpose.
         o_addr = i_fsr2 + {4'h0, i_f};
      end else if (i_f < rrc_pkg::ACCESS_SPLIT) begin
         o_addr = {4'h0, i_f};
      end else begin
         o_addr = {rrc_pkg::SFR_PAGE, i_f};
      end
   end

endmodule

/* src/rrc_rotate.sv */
`timescale 1ns/100ps
module rrc_rotate (
   input  wire logic [7:0] i_data,
   input  wire logic       i_carry,
   output logic      [7:0] o_result,
   output logic            o_carry,
   output logic            o_neg,
   output logic            o_zero
);

   always_comb begin
      o_result = {i_data[6:0], i_carry};
      o_carry  = i_data[7];
      o_neg    = o_result[7];
      o_zero   = (o_result == 8'h00);
   end

endmodule

/* testbench/rrc_core_sva.sv */
`timescale 1ns/100ps
module rrc_core_sva (
   input wire logic        i_clk,
   input wire logic        i_srst,
   input wire logic [15:0] i_instr,
   input wire logic [20:0] i_stack_top,
   input wire logic [7:0]  i_accumulator_shadow,
   input wire logic [7:0]  i_flag_shadow,
   input wire logic [3:0]  i_bank_select_shadow,
   input wire logic        i_ext_en,
   input wire logic [11:0] i_fsr2,
   input wire logic [7:0]  i_file_rdata,
   input wire logic [20:0] o_pc,
   input wire logic [7:0]  o_acc,
   input wire logic [7:0]  o_flags,
   input wire logic [3:0]  o_bank_select_register,
   input wire logic [1:0]  o_phase,
   input wire logic        o_instr_taken,
   input wire logic        o_stack_pop,
   input wire logic [11:0] o_file_addr,
   input wire logic        o_file_wr,
   input wire logic [7:0]  o_file_wdata
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   // A return is only counted once the decoder has accepted the word.
   sequence s_ret(s);
      o_phase == 2'h0 && i_instr == {rrc_pkg::OPC_RETURN[15:1], s}
      ##1 o_instr_taken;
   endsequence

   property p_rot_addr;
      logic [7:0] f;
      logic       a;
      (o_phase == 2'h0 && i_instr[15:10] == rrc_pkg::OPC_ROTATE_HI,
       f = i_instr[7:0], a = i_instr[8]) ##1 o_instr_taken |-> ##1
      o_file_addr == (a ? {o_bank_select_register, f} :
         f > rrc_pkg::INDEXED_LIMIT ? {rrc_pkg::SFR_PAGE, f} :
         i_ext_en ? i_fsr2 + {4'h0, f} : {4'h0, f});
   endproperty

   property p_rot_res;
      logic       d;
      logic [8:0] v;
      (o_phase == 2'h0 && i_instr[15:10] == rrc_pkg::OPC_ROTATE_HI,
       d = i_instr[9]) ##1 o_instr_taken
      ##1 (1'b1, v = {o_flags[0], i_file_rdata}) |-> ##2
      (o_flags[0] == v[7] && o_flags[4] == v[6] &&
       o_flags[2] == ({v[6:0], v[8]} == 8'h00) &&
       (d ? o_file_wr && o_file_wdata == {v[6:0], v[8]} :
        !o_file_wr && o_acc == {v[6:0], v[8]}));
   endproperty

   a_pop_loads_pc: assert property (
      o_stack_pop |-> o_pc == $past(i_stack_top))
      else $error("pc not loaded from stack top");
   a_pop_in_q1: assert property (
      o_stack_pop |-> o_phase == 2'h0 && $past(o_phase) == 2'h3)
      else $error("stack pop not after fourth phase");
   a_pop_spacing: assert property (
      o_stack_pop |=> !o_stack_pop [*7])
      else $error("stack pop too soon");
   a_ret_shadow: assert property (
      s_ret(1'b1) |-> ##3 (o_stack_pop &&
      o_acc == $past(i_accumulator_shadow) &&
      o_flags == $past(i_flag_shadow) &&
      o_bank_select_register == $past(i_bank_select_shadow)))
      else $error("shadow restore wrong");
   a_ret_keep: assert property (
      s_ret(1'b0) |=> ($stable(o_acc) && $stable(o_flags) &&
      $stable(o_bank_select_register)) [*7])
      else $error("plain return changed state");
   a_taken_pulse: assert property (
      o_instr_taken |-> o_phase == 2'h1 ##1 !o_instr_taken [*3])
      else $error("instruction taken pulse wrong");
   a_rot_addr: assert property (p_rot_addr)
      else $error("rotate address wrong");
   a_rot_result: assert property (p_rot_res)
      else $error("rotate result wrong");
endmodule

bind rrc_core rrc_core_sva rrc_core_sva_i (.i_clk, .i_srst, .i_instr,
   .i_stack_top, .i_accumulator_shadow, .i_flag_shadow,
   .i_bank_select_shadow, .i_ext_en, .i_fsr2, .i_file_rdata, .o_pc,
   .o_acc, .o_flags, .o_bank_select_register, .o_phase, .o_instr_taken,
   .o_stack_pop, .o_file_addr, .o_file_wr, .o_file_wdata);

/* testbench/return_and_rotate_carry_exec_bench.sv */
`timescale 1ns/100ps
module return_and_rotate_carry_exec_bench;
   logic        i_clk;
   logic        i_srst;
   logic [15:0] i_instr;
   logic [20:0] i_stack_top;
   logic [7:0]  i_accumulator_shadow;
   logic [7:0]  i_flag_shadow;
   logic [3:0]  i_bank_select_shadow;
   logic [4:0]  i_pc_upper_latch;
   logic [7:0]  i_pc_high_latch;
   logic        i_ext_en;
   logic [11:0] i_fsr2;
   logic [7:0]  i_file_rdata;
   logic [20:0] o_pc;
   logic [7:0]  o_acc;
   logic [7:0]  o_flags;
   logic [3:0]  o_bank_select_register;
   logic [1:0]  o_phase;
   logic        o_instr_taken;
   logic        o_stack_pop;
   logic [11:0] o_file_addr;
   logic        o_file_rd;
   logic        o_file_wr;
   logic [7:0]  o_file_wdata;
   int          errors;
   int          tests_run;

   rrc_core rrc_core_i (.i_clk, .i_srst, .i_instr, .i_stack_top,
      .i_accumulator_shadow, .i_flag_shadow, .i_bank_select_shadow,
      .i_pc_upper_latch, .i_pc_high_latch, .i_ext_en, .i_fsr2,
      .i_file_rdata, .o_pc, .o_acc, .o_flags, .o_bank_select_register,
      .o_phase, .o_instr_taken, .o_stack_pop, .o_file_addr, .o_file_rd,
      .o_file_wr, .o_file_wdata);

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Inputs move 1 ns after the edge so the design never sees a race.
   task step(input logic [15:0] w, input int n);
      i_instr = w;
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task tally_and_finish;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task rot_check(input logic [15:0] w, input logic [7:0] data,
                  input logic [11:0] ea, input logic [7:0] res,
                  input logic [7:0] fl);
      logic [7:0]  acc0;
      logic [20:0] pc0;
      acc0 = o_acc;
      pc0 = o_pc;
      i_file_rdata = data;
      step(w, 1);
      chk(o_instr_taken, 1'b1);
      step(w, 1);
      chk(o_file_rd, 1'b1);
      step(w, 2);
      chk(o_file_addr, ea);
      chk(o_flags, fl);
      chk(o_pc, pc0 + 21'h2);
      chk(o_file_wr, w[9]);
      chk(o_acc, w[9] ? acc0 : res);
      if (w[9]) chk(o_file_wdata, res);
   endtask

   task t_ret_shadow;
      i_stack_top = 21'h1abcd4;
      i_accumulator_shadow = 8'h5a;
      i_flag_shadow = 8'h01;
      i_bank_select_shadow = 4'h3;
      step(16'h0013, 4);
      chk(o_stack_pop, 1'b1);
      chk(o_pc, 21'h1abcd4);
      chk({o_acc, o_flags, o_bank_select_register}, 20'h5a013);
      i_stack_top = 21'h000100;
      step(16'h0013, 1);
      chk(o_instr_taken, 1'b0);
      step(16'h0013, 3);
      chk(o_pc, 21'h1abcd4);
      chk(o_stack_pop, 1'b0);
      $display("test ret_shadow done");
   endtask

   task t_ret_plain;
      i_stack_top = 21'h000400;
      i_accumulator_shadow = 8'hff;
      i_flag_shadow = 8'h1f;
      i_bank_select_shadow = 4'hc;
      i_pc_upper_latch = 5'h1f;
      i_pc_high_latch = 8'hee;
      step(16'h0012, 4);
      chk(o_pc, 21'h000400);
      chk({o_acc, o_flags, o_bank_select_register}, 20'h5a013);
      step(16'h0000, 4);
      // A neighbouring pattern must not decode as a return.
      step(16'h0010, 4);
      chk(o_stack_pop, 1'b0);
      chk(o_pc, 21'h000402);
      $display("test ret_plain done");
   endtask

   task t_rotate;
      rot_check(16'h3420, 8'he6, 12'h020, 8'hcd, 8'h11);
      rot_check(16'h3780, 8'h00, 12'h380, 8'h01, 8'h00);
      rot_check(16'h3670, 8'h80, 12'hf70, 8'h00, 8'h05);
      $display("test rotate done");
   endtask

   task t_rotate_ext;
      i_ext_en = 1'b1;
      i_fsr2 = 12'h100;
      rot_check(16'h345f, 8'h01, 12'h15f, 8'h03, 8'h00);
      rot_check(16'h3460, 8'h40, 12'hf60, 8'h80, 8'h10);
      i_ext_en = 1'b0;
      $display("test rotate_ext done");
   endtask

   task t_table;
      i_stack_top = 21'h000200;
      step(16'h0c04, 4);
      chk(o_acc, 8'h04);
      step(16'h0c04, 4);
      i_pc_upper_latch = 5'h01;
      i_pc_high_latch = 8'h23;
      i_file_rdata = 8'h10;
      step(16'h26f9, 4);
      chk(o_pc, 21'h012314);
      step(16'h26f9, 4);
      i_stack_top = 21'h000300;
      step(16'h0c77, 4);
      chk({o_acc, o_pc}, {8'h77, 21'h000300});
      step(16'h0000, 4);
      $display("test table done");
   endtask

   initial begin
      errors = 0;
      tests_run = 0;
      i_srst = 1'b1;
      i_instr = 16'h0000;
      i_stack_top = 21'h000000;
      i_accumulator_shadow = 8'h00;
      i_flag_shadow = 8'h00;
      i_bank_select_shadow = 4'h0;
      i_pc_upper_latch = 5'h00;
      i_pc_high_latch = 8'h00;
      i_ext_en = 1'b0;
      i_fsr2 = 12'h000;
      i_file_rdata = 8'h00;
      repeat (8) @(posedge i_clk);
      #1;
      i_srst = 1'b0;
      chk({o_pc, o_acc, o_flags, o_phase}, 39'h0);
      t_ret_shadow;
      t_ret_plain;
      t_rotate;
      t_rotate_ext;
      t_table;
      tally_and_finish;
   end

   // The tests need about 72 clocks; over forty times that means a hang.
   initial begin
      #24000;
      errors++;
      tally_and_finish;
   end
endmodule
